// ### src/tls_link_if.sv
// Register link between the lock search host and the tuner control end.
// Both ends sit on the same clock; no clocking block.
`default_nettype none

interface tls_link_if;
  logic wrEn;
  logic rdEn;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic rdValid;
  logic [7:0] rdata;

  modport host (output wrEn, output rdEn, output addr, output wdata,
                input rdValid, input rdata);
  modport dev (input wrEn, input rdEn, input addr, input wdata,
               output rdValid, output rdata);
endinterface

`default_nettype wire

// ### src/tls_lock_host.sv
// Lock search host: copies the calibration store after reset, programs
// divider and filter codes per channel, then steps oscillator settings
// until the lock indicator reads locked, a range end is hit or 24 readings pass. Software talks to it over APB.
// Assumes the tuner end answers link reads one cycle after rdEn.
//
// Functional notes
// - Program post-divider ratio per channel
// - Three oscillators, eight sub-bands each
// - Readings 001 to 110 mean locked
// - Reading 000 means step sub-band down
// - Reading 111 means step sub-band up
// - Repeat select and read until locked (the host also stops at either range end or after 24 readings)
// - Stop at first setting that locks
// - Copy overload code from store after reset
// - Write series filter code per channel
// - Write parallel filter code per channel
// - Digital channels use separately supplied codes
// - Store read: write address, read readback
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none

module tls_lock_host #(
  parameter int SETTLE_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to tuner
  tls_link_if.host link
);

  if (SETTLE_W < 1 || SETTLE_W > 16)
  begin : g_chk
    $error("tls_lock_host: SETTLE_W must be 1 to 16");
  end

  tls_pkg::tls_hstate_t state_q;
  logic [3:0] romIdx_q;
  logic [7:0] rom_q [tls_pkg::ROM_WORDS];
  logic calDone_q;
  logic busy_q;
  logic locked_q;
  logic fail_q;
  logic [2:0] lastLd_q;
  logic [4:0] idx_q;
  logic [4:0] tries_q;
  logic wrEn_q;
  logic rdEn_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic timerStart_q;
  logic timerDone;

  logic digital_q;
  logic [1:0] vdiv_q;
  logic [7:0] chanSer_q;
  logic [5:0] chanPar_q;
  logic [7:0] digSer_q;
  logic [5:0] digPar_q;
  logic [SETTLE_W-1:0] settle_q;
  logic startPulse_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic [31:0] rdMux;
  logic access;
  logic wrTake;
  logic [11:0] romOff;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write commits at the pready edge
  assign access = psel && penable;
  assign wrTake = access && pready_q && pwrite;
  assign romOff = paddr - tls_pkg::A_ROM0;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      tls_pkg::A_CTRL: rdMux[tls_pkg::CTRL_DIGITAL] = digital_q;
      tls_pkg::A_CHAN:
      begin
        rdMux[tls_pkg::CHAN_VDIV_LSB +: 2] = vdiv_q;
        rdMux[tls_pkg::CHAN_SER_LSB +: 8] = chanSer_q;
        rdMux[tls_pkg::CHAN_PAR_LSB +: 6] = chanPar_q;
      end
      tls_pkg::A_DCAP:
      begin
        rdMux[tls_pkg::DCAP_SER_LSB +: 8] = digSer_q;
        rdMux[tls_pkg::DCAP_PAR_LSB +: 6] = digPar_q;
      end
      tls_pkg::A_SETTLE: rdMux[SETTLE_W-1:0] = settle_q;
      tls_pkg::A_STATUS:
      begin
        rdMux[tls_pkg::ST_CAL] = calDone_q;
        rdMux[tls_pkg::ST_BUSY] = busy_q;
        rdMux[tls_pkg::ST_LOCK] = locked_q;
        rdMux[tls_pkg::ST_FAIL] = fail_q;
        rdMux[tls_pkg::ST_LD_LSB +: 3] = lastLd_q;
        rdMux[tls_pkg::ST_IDX_LSB +: 5] = idx_q;
      end
      default:
      begin
        // Calibration copy, one byte per word; unmapped reads give zero
        if (paddr[1:0] == 2'b00 && romOff[11:2] < 10'(tls_pkg::ROM_WORDS))
          rdMux[7:0] = rom_q[romOff[5:2]];
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= access && !pready_q;
      if (access && !pready_q && !pwrite)
        prdata_q <= rdMux;
    end
  end

  // Start is a pulse; a start while a search runs is ignored
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      digital_q <= 1'b0;
      vdiv_q <= 2'h0;
      chanSer_q <= 8'h00;
      chanPar_q <= 6'h00;
      digSer_q <= 8'h00;
      digPar_q <= 6'h00;
      settle_q <= tls_pkg::SETTLE_RST[SETTLE_W-1:0];
      startPulse_q <= 1'b0;
    end
    else
    begin
      startPulse_q <= wrTake && paddr == tls_pkg::A_CTRL && pwdata[tls_pkg::CTRL_START];
      if (wrTake)
      begin
        unique case (paddr)
          tls_pkg::A_CTRL: digital_q <= pwdata[tls_pkg::CTRL_DIGITAL];
          tls_pkg::A_CHAN:
          begin
            vdiv_q <= pwdata[tls_pkg::CHAN_VDIV_LSB +: 2];
            chanSer_q <= pwdata[tls_pkg::CHAN_SER_LSB +: 8];
            chanPar_q <= pwdata[tls_pkg::CHAN_PAR_LSB +: 6];
          end
          tls_pkg::A_DCAP:
          begin
            digSer_q <= pwdata[tls_pkg::DCAP_SER_LSB +: 8];
            digPar_q <= pwdata[tls_pkg::DCAP_PAR_LSB +: 6];
          end
          tls_pkg::A_SETTLE: settle_q <= pwdata[SETTLE_W-1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration store copy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < tls_pkg::ROM_WORDS; i++)
        rom_q[i] <= 8'h00;
    end
    else if (state_q == tls_pkg::HS_CAL_TAKE && link.rdValid)
      rom_q[romIdx_q] <= link.rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Settling timer
  tls_settle_timer #(
    .W(SETTLE_W)
  ) u_settle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(timerStart_q),
    .loadVal(settle_q),
    .done(timerDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and link drive
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= tls_pkg::HS_CAL_ADDR;
      romIdx_q <= 4'h0;
      calDone_q <= 1'b0;
      busy_q <= 1'b0;
      locked_q <= 1'b0;
      fail_q <= 1'b0;
      lastLd_q <= 3'h0;
      idx_q <= tls_pkg::FIRST_SETTING;
      tries_q <= 5'h00;
      wrEn_q <= 1'b0;
      rdEn_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      timerStart_q <= 1'b0;
    end
    else
    begin
      wrEn_q <= 1'b0;
      rdEn_q <= 1'b0;
      timerStart_q <= 1'b0;
      unique case (state_q)
        tls_pkg::HS_CAL_ADDR:
        begin
          wrEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_ROMA;
          wdata_q <= {4'h0, romIdx_q};
          state_q <= tls_pkg::HS_CAL_READ;
        end
        tls_pkg::HS_CAL_READ:
        begin
          rdEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_ROMD;
          state_q <= tls_pkg::HS_CAL_TAKE;
        end
        tls_pkg::HS_CAL_TAKE:
        begin
          if (link.rdValid)
          begin
            if (romIdx_q == 4'(tls_pkg::ROM_WORDS - 1))
              state_q <= tls_pkg::HS_CAL_OVLD;
            else
            begin
              romIdx_q <= romIdx_q + 4'h1;
              state_q <= tls_pkg::HS_CAL_ADDR;
            end
          end
        end
        tls_pkg::HS_CAL_OVLD:
        begin
          wrEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_OVLD;
          wdata_q <= {5'h00, rom_q[0][tls_pkg::OVLD_ROM_LSB +: 3]};
          calDone_q <= 1'b1;
          state_q <= tls_pkg::HS_IDLE;
        end
        tls_pkg::HS_IDLE:
        begin
          if (startPulse_q)
          begin
            busy_q <= 1'b1;
            locked_q <= 1'b0;
            fail_q <= 1'b0;
            idx_q <= tls_pkg::FIRST_SETTING;
            tries_q <= 5'h00;
            state_q <= tls_pkg::HS_PROG_SER;
          end
        end
        tls_pkg::HS_PROG_SER:
        begin
          wrEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_SER;
          wdata_q <= digital_q ? digSer_q : chanSer_q;
          state_q <= tls_pkg::HS_PROG_PAR;
        end
        tls_pkg::HS_PROG_PAR:
        begin
          wrEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_PAR;
          wdata_q <= {2'b00, digital_q ? digPar_q : chanPar_q};
          state_q <= tls_pkg::HS_SEL;
        end
        tls_pkg::HS_SEL:
        begin
          wrEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_VCO;
          wdata_q <= {1'b0, vdiv_q, idx_q};
          timerStart_q <= 1'b1;
          state_q <= tls_pkg::HS_SETTLE;
        end
        tls_pkg::HS_SETTLE:
        begin
          if (timerDone)
            state_q <= tls_pkg::HS_LD_READ;
        end
        tls_pkg::HS_LD_READ:
        begin
          rdEn_q <= 1'b1;
          addr_q <= tls_pkg::LA_LOCK;
          state_q <= tls_pkg::HS_LD_TAKE;
        end
        tls_pkg::HS_LD_TAKE:
        begin
          if (link.rdValid)
          begin
            lastLd_q <= link.rdata[2:0];
            tries_q <= tries_q + 5'h01;
            if (tls_pkg::tls_ld_locked(link.rdata[2:0]))
            begin
              // First setting that locks is kept
              locked_q <= 1'b1;
              busy_q <= 1'b0;
              state_q <= tls_pkg::HS_IDLE;
            end
            else if ((link.rdata[2:0] == tls_pkg::LD_BOTTOM && idx_q == 5'h00) ||
                     (link.rdata[2:0] == tls_pkg::LD_TOP &&
                      idx_q == tls_pkg::LAST_SETTING) ||
                     tries_q == tls_pkg::LAST_SETTING)
            begin
              // Out of range, or 24 readings taken without a lock
              fail_q <= 1'b1;
              busy_q <= 1'b0;
              state_q <= tls_pkg::HS_IDLE;
            end
            else
            begin
              if (link.rdata[2:0] == tls_pkg::LD_BOTTOM)
                idx_q <= idx_q - 5'h01;
              else
                idx_q <= idx_q + 5'h01;
              state_q <= tls_pkg::HS_SEL;
            end
          end
        end
      endcase
    end
  end

  assign link.wrEn = wrEn_q;
  assign link.rdEn = rdEn_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = 1'b0;

endmodule

`default_nettype wire

// ### src/tls_pkg.sv
// Shared constants for the tuner lock search pair: link register map,
// field positions, reset values, host register map and host states.
// Assumes a single 10 MHz system clock on both ends.
`default_nettype none

package tls_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clocking and timing
  localparam int CLK_MHZ = 10;
  localparam int SETTLE_US = 10;
  localparam logic [15:0] SETTLE_RST = 16'(SETTLE_US * CLK_MHZ);

  ////////////////////////////////////////////////////////////////////////
  // Tuner link register addresses
  localparam logic [2:0] LA_VCO = 3'h0;
  localparam logic [2:0] LA_SER = 3'h1;
  localparam logic [2:0] LA_PAR = 3'h2;
  localparam logic [2:0] LA_ROMA = 3'h3;
  localparam logic [2:0] LA_ROMD = 3'h4;
  localparam logic [2:0] LA_OVLD = 3'h5;
  localparam logic [2:0] LA_LOCK = 3'h6;

  // Oscillator register fields: sub-band [2:0], oscillator [4:3], divider [6:5]
  localparam int SUB_LSB = 0;
  localparam int VSEL_LSB = 3;
  localparam int VDIV_LSB = 5;

  // Calibration store and synthesizer geometry
  localparam int ROM_WORDS = 9;
  localparam int OVLD_ROM_LSB = 5;
  localparam int NUM_VCO = 3;
  localparam int NUM_SUB = 8;
  localparam logic [4:0] LAST_SETTING = 5'(NUM_VCO * NUM_SUB - 1);
  localparam logic [4:0] FIRST_SETTING = 5'h0C;

  localparam logic [2:0] LD_BOTTOM = 3'h0;
  localparam logic [2:0] LD_TOP = 3'h7;
  localparam logic [2:0] LD_LOCK_BASE = 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // Host APB register map (byte addresses)
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_CHAN = 12'h004;
  localparam logic [11:0] A_DCAP = 12'h008;
  localparam logic [11:0] A_SETTLE = 12'h00C;
  localparam logic [11:0] A_STATUS = 12'h010;
  localparam logic [11:0] A_ROM0 = 12'h020;

  localparam int CTRL_START = 0;
  localparam int CTRL_DIGITAL = 1;
  localparam int CHAN_VDIV_LSB = 0;
  localparam int CHAN_SER_LSB = 8;
  localparam int CHAN_PAR_LSB = 16;
  localparam int DCAP_SER_LSB = 0;
  localparam int DCAP_PAR_LSB = 8;
  localparam int ST_CAL = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_LD_LSB = 4;
  localparam int ST_IDX_LSB = 8;

  ////////////////////////////////////////////////////////////////////////
  // Host sequencer states
  typedef enum logic [10:0] {
    HS_CAL_ADDR = 11'h001,
    HS_CAL_READ = 11'h002,
    HS_CAL_TAKE = 11'h004,
    HS_CAL_OVLD = 11'h008,
    HS_IDLE = 11'h010,
    HS_PROG_SER = 11'h020,
    HS_PROG_PAR = 11'h040,
    HS_SEL = 11'h080,
    HS_SETTLE = 11'h100,
    HS_LD_READ = 11'h200,
    HS_LD_TAKE = 11'h400
  } tls_hstate_t;

  // Lock indicator inside the locked band
  function automatic logic tls_ld_locked(input logic [2:0] ld);
    return (ld != LD_BOTTOM) && (ld != LD_TOP);
  endfunction

endpackage

`default_nettype wire

// ### src/tls_settle_timer.sv
// Settling delay counter used by the host between a setting change and
// the lock read. Assumes start is a one-cycle pulse on sys_clk.
`default_nettype none

module tls_settle_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [W-1:0] loadVal,
  output logic done
);

  if (W < 1)
  begin : g_chk
    $error("tls_settle_timer: W must be at least 1");
  end

  logic [W-1:0] count_q;
  logic done_q;

  // A zero load still waits one cycle so the read never precedes the write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      count_q <= (loadVal == '0) ? W'(1) : loadVal;
      done_q <= 1'b0;
    end
    else
    begin
      if (count_q != '0)
        count_q <= count_q - W'(1);
      done_q <= (count_q == W'(1));
    end
  end

  assign done = done_q;

endmodule

`default_nettype wire

// ### src/tls_tuner_dev.sv
// Tuner control end: link registers, calibration store, synthesizer lock
// indicator model. lockTarget is a same-clock input naming the setting
// (oscillator * 8 + sub-band) at which the loop would lock.
`default_nettype none

module tls_tuner_dev #(
  // Arbitrary calibration contents, byte i at bits [8*i+7:8*i]
  parameter logic [71:0] ROM_INIT = 72'h5A_A5_3C_C3_69_96_0F_F0_A0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  tls_link_if.dev link,
  // Synthesizer model
  input wire logic [4:0] lockTarget,
  // Tuner settings
  output logic [1:0] vcoPostDivSel,
  output logic [1:0] vcoSel,
  output logic [2:0] subBand,
  output logic [7:0] filterSeriesCapCode,
  output logic [5:0] filterParallelCapCode,
  output logic [2:0] overloadCalCode
);

  logic [6:0] vcoReg_q;
  logic [7:0] ser_q;
  logic [5:0] par_q;
  logic [3:0] romAddr_q;
  logic [7:0] romData_q;
  logic [2:0] ovld_q;
  logic [2:0] ld_q;
  logic rdValid_q;
  logic [7:0] rdata_q;
  logic [4:0] setting;

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vcoReg_q <= 7'h00;
      ser_q <= 8'h00;
      par_q <= 6'h00;
      romAddr_q <= 4'h0;
      ovld_q <= 3'h0;
    end
    else if (link.wrEn)
    begin
      unique case (link.addr)
        tls_pkg::LA_VCO: vcoReg_q <= link.wdata[6:0];
        tls_pkg::LA_SER: ser_q <= link.wdata;
        tls_pkg::LA_PAR: par_q <= link.wdata[5:0];
        tls_pkg::LA_ROMA: romAddr_q <= link.wdata[3:0];
        tls_pkg::LA_OVLD: ovld_q <= link.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Address write loads the addressed byte into the readback field
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      romData_q <= 8'h00;
    else if (link.wrEn && link.addr == tls_pkg::LA_ROMA)
      romData_q <= (link.wdata[3:0] < 4'(tls_pkg::ROM_WORDS)) ?
                   ROM_INIT[8*link.wdata[3:0] +: 8] : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Synthesizer: three oscillators by eight sub-bands
  // Oscillator bits sit directly above the sub-band bits, so the pair is the index
  assign setting = vcoReg_q[tls_pkg::SUB_LSB +: 5];

  // Too high a setting pins the oscillator low, too low pins it high
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ld_q <= tls_pkg::LD_BOTTOM;
    else if (setting > lockTarget)
      ld_q <= tls_pkg::LD_BOTTOM;
    else if (setting < lockTarget)
      ld_q <= tls_pkg::LD_TOP;
    else
      ld_q <= tls_pkg::LD_LOCK_BASE + {1'b0, setting[1:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Read answer, one cycle after rdEn
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdValid_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      rdValid_q <= link.rdEn;
      if (link.rdEn)
      begin
        unique case (link.addr)
          tls_pkg::LA_VCO: rdata_q <= {1'b0, vcoReg_q};
          tls_pkg::LA_SER: rdata_q <= ser_q;
          tls_pkg::LA_PAR: rdata_q <= {2'b00, par_q};
          tls_pkg::LA_ROMA: rdata_q <= {4'h0, romAddr_q};
          tls_pkg::LA_ROMD: rdata_q <= romData_q;
          tls_pkg::LA_OVLD: rdata_q <= {5'h00, ovld_q};
          tls_pkg::LA_LOCK: rdata_q <= {5'h00, ld_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign link.rdValid = rdValid_q;
  assign link.rdata = rdata_q;
  assign vcoPostDivSel = vcoReg_q[tls_pkg::VDIV_LSB +: 2];
  assign vcoSel = vcoReg_q[tls_pkg::VSEL_LSB +: 2];
  assign subBand = vcoReg_q[tls_pkg::SUB_LSB +: 3];
  assign filterSeriesCapCode = ser_q;
  assign filterParallelCapCode = par_q;
  assign overloadCalCode = ovld_q;

endmodule

`default_nettype wire

// ### tb/tls_props.sv
// Checker on the link between the lock search host and the tuner end.
// Assumes every signal is sampled on the rising edge of sys_clk.
`default_nettype none

module tls_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rdValid,
  input wire logic [7:0] rdata
);
  logic [4:0] lastIdx_q;
  logic ldRead_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Last setting sent, so that a lock reading can be judged against it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lastIdx_q <= 5'h00;
    else if (wrEn && addr == tls_pkg::LA_VCO)
      lastIdx_q <= wdata[4:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ldRead_q <= 1'b0;
    else
      ldRead_q <= rdEn && addr == tls_pkg::LA_LOCK;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_ld_answer(logic [2:0] v);
    rdValid && ldRead_q && rdata[2:0] == v;
  endsequence

  sequence s_vco_write(logic [4:0] idx);
    wrEn && addr == tls_pkg::LA_VCO && wdata[4:0] == idx;
  endsequence

  a_read_answer: assert property (rdEn |=> rdValid)
    else $error("link read not answered");
  a_valid_cause: assert property (rdValid |-> $past(rdEn))
    else $error("read answer without request");
  a_one_op: assert property (!(wrEn && rdEn))
    else $error("two link operations at once");
  a_rom_then_read: assert property (wrEn && addr == tls_pkg::LA_ROMA
    |=> rdEn && addr == tls_pkg::LA_ROMD)
    else $error("store address not followed by readback");
  a_step_down: assert property (s_ld_answer(3'h0) ##0 lastIdx_q != 5'h00
    |-> ##[1:8] s_vco_write(lastIdx_q - 5'h01))
    else $error("bottom reading not followed by lower setting");
  a_step_up: assert property (s_ld_answer(3'h7) ##0 lastIdx_q != 5'h17
    |-> ##[1:8] s_vco_write(lastIdx_q + 5'h01))
    else $error("top reading not followed by higher setting");
  a_lock_stops: assert property (rdValid && ldRead_q && rdata[2:0] != 3'h0
    && rdata[2:0] != 3'h7 |=> !wrEn [*3])
    else $error("search went on after lock");
  a_settle_wait: assert property (rdEn && addr == tls_pkg::LA_LOCK |-> !$past(wrEn))
    else $error("lock read without settling");
  a_osc_range: assert property (wrEn && addr == tls_pkg::LA_VCO
    |-> wdata[4:0] <= tls_pkg::LAST_SETTING && !wdata[7])
    else $error("oscillator setting out of range");
endmodule

`default_nettype wire

// ### tb/tuner_lock_search_sequencer_bench.sv
// Bench for the lock search pair: host driven over APB, tuner end on link.
// Assumes the package, interface, design modules and checker come first.
`default_nettype none

module tuner_lock_search_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [71:0] ROM = 72'h5A_A5_3C_C3_69_96_0F_F0_A0;
  typedef struct packed {logic [4:0] tgt; logic [1:0] vdiv; logic [7:0] ser; logic [5:0] par;} tls_row_t;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] lockTarget;
  logic [1:0] vcoPostDivSel, vcoSel;
  logic [2:0] subBand, overloadCalCode, ld;
  logic [7:0] filterSeriesCapCode;
  logic [5:0] filterParallelCapCode;
  int failures, n_checks;
  // Start index is 12, so these go nowhere, down, up, to both ends
  tls_row_t rows [5] = '{'{5'h0C, 2'h0, 8'h11, 6'h01}, '{5'h05, 2'h1, 8'hFF, 6'h3F},
    '{5'h14, 2'h2, 8'h80, 6'h20}, '{5'h00, 2'h3, 8'h00, 6'h15}, '{5'h17, 2'h1, 8'h5A, 6'h2A}};

  tls_link_if link();
  tls_lock_host i_tls_lock_host (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  tls_tuner_dev #(.ROM_INIT(ROM)) i_tls_tuner_dev (.sys_clk, .rst_n, .link(link),
    .lockTarget, .vcoPostDivSel, .vcoSel, .subBand, .filterSeriesCapCode,
    .filterParallelCapCode, .overloadCalCode);
  tls_props i_tls_props (.sys_clk, .rst_n, .wrEn(link.wrEn), .rdEn(link.rdEn),
    .addr(link.addr), .wdata(link.wdata), .rdValid(link.rdValid), .rdata(link.rdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask

  // Ends one edge after release, so the next call never re-drives psel
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50)
      failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_cal();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, tls_pkg::A_STATUS, 32'h0);
      n++;
    end
    while (rd[tls_pkg::ST_CAL] !== 1'b1 && n < 100);
  endtask

  task automatic run_search(input logic [31:0] ctrl, input logic [31:0] exp);
    int n;
    n = 0;
    apb(1'b1, tls_pkg::A_CTRL, ctrl);
    do
    begin
      apb(1'b0, tls_pkg::A_STATUS, 32'h0);
      n++;
    end
    while (rd[tls_pkg::ST_BUSY] !== 1'b0 && n < 400);
    chkReg(rd, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    lockTarget = 5'h0C;
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    wait_cal();
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, tls_pkg::A_ROM0 + 12'(4 * i), 32'h0);
      chkReg(rd, {24'h0, ROM[8 * i +: 8]});
    end
    chkPin({5'h00, overloadCalCode}, {5'h00, ROM[7:5]});
    apb(1'b0, 12'h0FC, 32'h0);
    chkReg(rd, 32'h0);
    chkPin({7'h00, pslverr}, 8'h00);
    apb(1'b1, tls_pkg::A_SETTLE, 32'h2);
    apb(1'b0, tls_pkg::A_SETTLE, 32'h0);
    chkReg(rd, 32'h2);
    $display("calibration test done");
    foreach (rows[i])
    begin
      lockTarget <= rows[i].tgt;
      apb(1'b1, tls_pkg::A_CHAN, {10'h0, rows[i].par, rows[i].ser, 6'h0, rows[i].vdiv});
      ld = 3'h1 + {1'b0, rows[i].tgt[1:0]};
      run_search(32'h1, {19'h0, rows[i].tgt, 1'b0, ld, 4'h5});
      chkPin({6'h0, vcoPostDivSel}, {6'h0, rows[i].vdiv});
      chkPin({3'h0, vcoSel, subBand}, {3'h0, rows[i].tgt});
      chkPin(filterSeriesCapCode, rows[i].ser);
      chkPin({2'h0, filterParallelCapCode}, {2'h0, rows[i].par});
    end
    $display("table test done");
    lockTarget <= 5'h1F;
    run_search(32'h1, {19'h0, 5'h17, 1'b0, 3'h7, 4'h9});
    $display("no lock test done");
    lockTarget <= 5'h0C;
    apb(1'b1, tls_pkg::A_DCAP, {18'h0, 6'h2A, 8'hC5});
    run_search(32'h3, {19'h0, 5'h0C, 1'b0, 3'h1, 4'h5});
    chkPin(filterSeriesCapCode, 8'hC5);
    chkPin({2'h0, filterParallelCapCode}, 8'h2A);
    $display("digital test done");
    // Reset in mid-search must clear everything and redo calibration
    lockTarget <= 5'h00;
    apb(1'b1, tls_pkg::A_CTRL, 32'h1);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    chkPin({vcoPostDivSel, vcoSel, subBand, 1'b0}, 8'h00);
    chkPin(filterSeriesCapCode, 8'h00);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, tls_pkg::A_STATUS, 32'h0);
    // Copy still running; the search index rests at its start point
    chkReg(rd, {19'h0, tls_pkg::FIRST_SETTING, 8'h00});
    wait_cal();
    chkPin({5'h00, overloadCalCode}, {5'h00, ROM[7:5]});
    $display("reset test done");
    stop_test();
  end
endmodule

`default_nettype wire
